// ===== src/link_bit_capture.sv
// Serial bit capture running on the bus clock.
`timescale 1ns/1ps
module link_bit_capture (
	input wire logic scl, // Bus clock from the host
	input wire logic sda_in, // Bus data level
	output logic [7:0] link_byte // Last eight bits seen
);

	// ------------------------------------------------------------
	// Shift in data on each rising bus clock
	// ------------------------------------------------------------
	// Stands still between frames; the system side reads it only
	// after it has seen the matching edge through its synchroniser.
	always_ff @(posedge scl) begin
		link_byte <= {link_byte[6:0], sda_in};
	end

endmodule

// ===== src/param_gateway_pkg.sv
// Constants and types shared by the parameter memory gateway.
package param_gateway_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_STAT_HI = 8'h01;
	localparam logic [7:0] OFF_STAT_LO = 8'h02;
	localparam logic [7:0] OFF_SPM_STAT = 8'h08;
	localparam logic [7:0] OFF_CFG = 8'h0D;
	localparam logic [7:0] OFF_BASE = 8'h0E;
	localparam logic [7:0] OFF_KEY_UPPER = 8'hAC;
	localparam logic [7:0] OFF_KEY_LOWER = 8'hAD;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CFG_MODE_MSB = 5;
	localparam int CFG_MODE_LSB = 4;
	localparam int CFG_DIR_BIT = 3;
	localparam int STAT_DONE_BIT = 6;
	localparam int STAT_COUNT_LSB = 5;
	localparam int NVM_VALID_BIT = 3;

	// ------------------------------------------------------------
	// Values, reset values and counts
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SPM = 2'h1;
	localparam logic [7:0] KEY_UPPER_VAL = 8'h62;
	localparam logic [7:0] KEY_LOWER_VAL = 8'h9D;
	localparam logic [7:0] TRIG_FIRST = 8'hA5;
	localparam logic [7:0] TRIG_SECOND = 8'h5A;
	localparam logic [7:0] BASE_RESET = 8'h00;
	localparam logic [7:0] BASE_MAX = 8'h78;
	localparam logic [3:0] BURST_LEN = 4'h8;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] MAX_BURNS = 3'h3;
	localparam logic [2:0] BURN_SAT = 3'h4;
	localparam int SHADOW_DEPTH = 128;
	localparam logic [6:0] COPY_LAST = 7'h7F;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] mode;
		logic dir;
	} cfg_type;

	localparam cfg_type CFG_RESET = '{mode: MODE_NORMAL, dir: 1'b0};

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA
	} bus_state_type;

	typedef enum logic [1:0] {
		KEY_IDLE, KEY_UPPER_OK, KEY_BOTH_OK, KEY_TRIG1
	} key_state_type;

endpackage

// ===== src/param_memory_gateway_burn.sv
// Parameter shadow memory gateway with keyed burn, behind a two-wire slave.
// Function
// - Transfers are exactly eight-byte bursts.
// - Upper key 0xAC unlocks only with 0x62.
// - Lower key 0xAD unlocks only with 0x9D.
// - Read burst: mode 01, direction 1, read 0-7.
// - Applied write burst asserts active-low interrupt.
// - Any read clears interrupt and done bit.
// - Applied read burst asserts interrupt too.
// - Burn count shown in lower status 7:5.
// - Counter starts zero, factory set; burns increment.
// - Fourth burn reverts permanently to factory set.
// - Burn needs keys then 0xA5, 0x5A to base.
// - Config: mode 5:4, direction 3, reset zero.
// - Base register at 0x0E, resets 0x00.
`timescale 1ns/1ps
module param_memory_gateway_burn
	import param_gateway_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2B // Bus address, arbitrary value
) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic scl, // Bus clock pin
	input wire logic sda_in, // Bus data pin level
	output logic sda_out, // Bus data drive value
	output logic sda_oe, // Bus data drive enable
	output logic irq_n, // Transfer done interrupt, active low
	output logic params_from_nvm // Burned parameters in use
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0] link_byte;
	logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
	logic start_cond, stop_cond, scl_rise, scl_fall;
	bus_state_type st;
	logic [3:0] bit_cnt;
	logic ack_phase, mack;
	logic [7:0] reg_ptr, rd_shift, rd_value;
	logic wr_stb, rd_stb;
	logic [7:0] wr_addr, wr_data, rd_addr;
	cfg_type cfg;
	logic [7:0] base;
	logic [3:0] burst_cnt;
	logic xfer_done, burst_done, spm_mode, terminate;
	key_state_type key_st;
	logic burn_fire, copy_busy, nvm_valid;
	logic [6:0] copy_idx;
	logic [2:0] burn_count;
	logic [7:0] shadow_param_ram [SHADOW_DEPTH];
	logic [7:0] nvm_store [SHADOW_DEPTH];

	// ------------------------------------------------------------
	// Bus clock domain capture
	// ------------------------------------------------------------
	link_bit_capture link_bit_capture_inst (
		.scl(scl),
		.sda_in(sda_in),
		.link_byte(link_byte)
	);

	// Open drain: the line is only ever pulled low
	assign sda_out = 1'b0;

	// ------------------------------------------------------------
	// Pin synchronisers and bus condition detection
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_q <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_m <= scl;
			scl_s <= scl_m;
			scl_q <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_q <= sda_s;
		end
	end

	// Data edges while the clock is high mark frame start and end
	assign start_cond = scl_s && scl_q && sda_q && !sda_s;
	assign stop_cond = scl_s && scl_q && !sda_q && sda_s;
	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;

	// ------------------------------------------------------------
	// Slave protocol engine
	// ------------------------------------------------------------
	// The captured byte is stable from its eighth rising edge until
	// the next one, so it is safe to take on the following fall.
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= ST_IDLE;
			bit_cnt <= 4'h0;
			ack_phase <= 1'b0;
			mack <= 1'b0;
			sda_oe <= 1'b0;
			reg_ptr <= 8'h00;
			rd_shift <= 8'h00;
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			rd_addr <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			if (start_cond) begin
				st <= ST_ADDR;
				bit_cnt <= 4'h0;
				ack_phase <= 1'b0;
				sda_oe <= 1'b0;
			end else if (stop_cond) begin
				st <= ST_IDLE;
				ack_phase <= 1'b0;
				sda_oe <= 1'b0;
			end else if (st != ST_IDLE) begin
				if (scl_rise) begin
					if (!ack_phase) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (st == ST_RDATA) begin
						mack <= !sda_s;
					end
				end else if (scl_fall) begin
					if (!ack_phase && bit_cnt == BITS_PER_BYTE) begin
						ack_phase <= 1'b1;
						bit_cnt <= 4'h0;
						case (st)
							ST_ADDR: begin
								if (link_byte[7:1] == DEV_ADDR) begin
									sda_oe <= 1'b1;
									mack <= 1'b1;
									st <= link_byte[0] ? ST_RDATA : ST_REG;
								end else begin
									sda_oe <= 1'b0;
									st <= ST_IDLE;
								end
							end
							ST_REG: begin
								reg_ptr <= link_byte;
								sda_oe <= 1'b1;
								st <= ST_WDATA;
							end
							ST_WDATA: begin
								wr_stb <= 1'b1;
								wr_addr <= reg_ptr;
								wr_data <= link_byte;
								reg_ptr <= reg_ptr + 8'h01;
								sda_oe <= 1'b1;
							end
							default: begin
								sda_oe <= 1'b0; // Host answers here
							end
						endcase
					end else if (ack_phase) begin
						ack_phase <= 1'b0;
						if (st == ST_RDATA && mack) begin
							rd_stb <= 1'b1;
							rd_addr <= reg_ptr;
							reg_ptr <= reg_ptr + 8'h01;
							rd_shift <= {rd_value[6:0], 1'b0};
							sda_oe <= !rd_value[7];
						end else begin
							sda_oe <= 1'b0;
							if (st == ST_RDATA) begin
								st <= ST_IDLE;
							end
						end
					end else if (st == ST_RDATA) begin
						sda_oe <= !rd_shift[7];
						rd_shift <= {rd_shift[6:0], 1'b0};
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Register read multiplexer
	// ------------------------------------------------------------
	assign spm_mode = cfg.mode == MODE_SPM;

	always_comb begin
		rd_value = 8'h00;
		if (spm_mode && cfg.dir && reg_ptr[7:3] == 5'h00) begin
			rd_value = shadow_param_ram[{base[6:3], reg_ptr[2:0]}];
		end else if (reg_ptr == OFF_CFG) begin
			rd_value[CFG_MODE_MSB:CFG_MODE_LSB] = cfg.mode;
			rd_value[CFG_DIR_BIT] = cfg.dir;
		end else if (reg_ptr == OFF_BASE) begin
			rd_value = base;
		end else if (reg_ptr == OFF_STAT_HI) begin
			rd_value[STAT_DONE_BIT] = xfer_done;
		end else if (reg_ptr == OFF_STAT_LO) begin
			rd_value[STAT_COUNT_LSB+:3] = burn_count;
		end else if (reg_ptr == OFF_SPM_STAT) begin
			rd_value[NVM_VALID_BIT] = nvm_valid;
			rd_value[2:0] = burn_count;
		end
	end

	// ------------------------------------------------------------
	// Configuration and base address registers
	// ------------------------------------------------------------
	assign terminate = wr_stb && wr_addr == OFF_CFG && wr_data[5:3] == 3'b000;

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg <= CFG_RESET;
			base <= BASE_RESET;
		end else if (wr_stb) begin
			if (wr_addr == OFF_CFG) begin
				cfg.mode <= wr_data[CFG_MODE_MSB:CFG_MODE_LSB];
				cfg.dir <= wr_data[CFG_DIR_BIT];
			end else if (wr_addr == OFF_BASE) begin
				base <= wr_data;
			end
		end
	end

	// ------------------------------------------------------------
	// Shadow memory write port
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (wr_stb && spm_mode && !cfg.dir && wr_addr[7:3] == 5'h00) begin
			shadow_param_ram[{base[6:3], wr_addr[2:0]}] <= wr_data;
		end
	end

	// ------------------------------------------------------------
	// Burst byte counter and completion flag
	// ------------------------------------------------------------
	// A burst counts only when exactly eight shadow bytes moved
	// since the last configuration or base write.
	assign burst_done = terminate && spm_mode && burst_cnt == BURST_LEN;

	always_ff @(posedge clk) begin
		if (rst) begin
			burst_cnt <= 4'h0;
		end else if (wr_stb && (wr_addr == OFF_CFG || wr_addr == OFF_BASE)) begin
			burst_cnt <= 4'h0;
		end else if (spm_mode && burst_cnt <= BURST_LEN) begin
			if ((wr_stb && !cfg.dir && wr_addr[7:3] == 5'h00) ||
					(rd_stb && cfg.dir && rd_addr[7:3] == 5'h00)) begin
				burst_cnt <= burst_cnt + 4'h1;
			end
		end
	end

	// Setting wins over the clear of a read in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			xfer_done <= 1'b0;
		end else if (burst_done) begin
			xfer_done <= 1'b1;
		end else if (rd_stb) begin
			xfer_done <= 1'b0;
		end
	end

	assign irq_n = !xfer_done;

	// ------------------------------------------------------------
	// Burn unlock sequence
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			key_st <= KEY_IDLE;
		end else if (wr_stb) begin
			key_st <= KEY_IDLE;
			case (key_st)
				KEY_IDLE: begin
					if (wr_addr == OFF_KEY_UPPER && wr_data == KEY_UPPER_VAL) begin
						key_st <= KEY_UPPER_OK;
					end
				end
				KEY_UPPER_OK: begin
					if (wr_addr == OFF_KEY_LOWER && wr_data == KEY_LOWER_VAL) begin
						key_st <= KEY_BOTH_OK;
					end else if (wr_addr == OFF_KEY_UPPER && wr_data == KEY_UPPER_VAL) begin
						key_st <= KEY_UPPER_OK;
					end
				end
				KEY_BOTH_OK: begin
					if (wr_addr == OFF_BASE && wr_data == TRIG_FIRST) begin
						key_st <= KEY_TRIG1;
					end
				end
				default: begin
					key_st <= KEY_IDLE;
				end
			endcase
		end
	end

	assign burn_fire = wr_stb && key_st == KEY_TRIG1 && wr_addr == OFF_BASE &&
		wr_data == TRIG_SECOND && !copy_busy;

	// ------------------------------------------------------------
	// Burn counter and non-volatile copy
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			burn_count <= 3'h0;
			nvm_valid <= 1'b0;
			copy_busy <= 1'b0;
			copy_idx <= 7'h00;
		end else if (copy_busy) begin
			copy_idx <= copy_idx + 7'h01;
			if (copy_idx == COPY_LAST) begin
				copy_busy <= 1'b0;
				nvm_valid <= 1'b1;
			end
		end else if (burn_fire && burn_count != BURN_SAT) begin
			burn_count <= burn_count + 3'h1;
			if (burn_count == MAX_BURNS) begin
				nvm_valid <= 1'b0;
			end else begin
				copy_busy <= 1'b1;
				copy_idx <= 7'h00;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (copy_busy) begin
			nvm_store[copy_idx] <= shadow_param_ram[copy_idx];
		end
	end

	assign params_from_nvm = nvm_valid;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_DONE_NEEDS_EIGHT: assert property (@(posedge clk) disable iff (rst)
		$rose(xfer_done) |-> $past(burst_cnt) == BURST_LEN && $past(terminate))
		else $error("done flag set without an eight byte burst");

	AST_UPPER_KEY: assert property (@(posedge clk) disable iff (rst)
		key_st == KEY_UPPER_OK && $past(key_st) == KEY_IDLE |->
		$past(wr_addr) == OFF_KEY_UPPER && $past(wr_data) == KEY_UPPER_VAL)
		else $error("unlock step one without upper key");

	AST_LOWER_KEY: assert property (@(posedge clk) disable iff (rst)
		$changed(key_st) && key_st == KEY_BOTH_OK |->
		$past(wr_addr) == OFF_KEY_LOWER && $past(wr_data) == KEY_LOWER_VAL)
		else $error("unlock step two without lower key");

	AST_IRQ_ON_BURST: assert property (@(posedge clk) disable iff (rst)
		burst_done |=> !irq_n && xfer_done)
		else $error("interrupt not raised after burst");

	AST_READ_CLEARS: assert property (@(posedge clk) disable iff (rst)
		rd_stb && !burst_done |=> irq_n && !xfer_done)
		else $error("register read left interrupt pending");

	AST_IRQ_HOLDS: assert property (@(posedge clk) disable iff (rst)
		!irq_n && !rd_stb |=> !irq_n)
		else $error("interrupt dropped without a read");

	AST_COUNT_VISIBLE: assert property (@(posedge clk) disable iff (rst)
		reg_ptr == OFF_STAT_LO && !(spm_mode && cfg.dir) |-> rd_value[7:5] == burn_count)
		else $error("burn count not shown in lower status");

	AST_BURN_INC: assert property (@(posedge clk) disable iff (rst)
		burn_fire && !copy_busy && burn_count != BURN_SAT |=> burn_count == $past(burn_count) + 3'h1)
		else $error("burn did not advance the counter");

	AST_FOURTH_BURN: assert property (@(posedge clk) disable iff (rst)
		burn_fire && burn_count == MAX_BURNS |=> !params_from_nvm [*8])
		else $error("fourth burn left burned parameters in use");

	AST_BURN_KEYED: assert property (@(posedge clk) disable iff (rst)
		$rose(copy_busy) |-> $past(key_st) == KEY_TRIG1 && $past(wr_data) == TRIG_SECOND)
		else $error("burn started without the full sequence");

	AST_SEQ_ABORT: assert property (@(posedge clk) disable iff (rst)
		wr_stb && key_st == KEY_BOTH_OK && !(wr_addr == OFF_BASE && wr_data == TRIG_FIRST)
		|=> key_st == KEY_IDLE)
		else $error("unlock kept after a wrong write");

	AST_WINDOW_MAP: assert property (@(posedge clk) disable iff (rst)
		spm_mode && cfg.dir && reg_ptr == 8'h03 |->
		rd_value == shadow_param_ram[{base[6:3], 3'h3}])
		else $error("window read not served by shadow memory");

	COV_WRITE_BURST: cover property (@(posedge clk) disable iff (rst) burst_done && !cfg.dir);
	COV_READ_BURST: cover property (@(posedge clk) disable iff (rst) burst_done && cfg.dir);
	COV_BURN: cover property (@(posedge clk) disable iff (rst) $fell(copy_busy));
	COV_FOURTH: cover property (@(posedge clk) disable iff (rst) burn_count == BURN_SAT);

endmodule

// ===== testbench/i2c_host_model.sv
// Two-wire bus host model that drives the gateway's serial port.
`timescale 1ns/1ps
module i2c_host_model #(
	parameter int HALF_NS = 96 // Half bit time, at least eight system clocks
) (
	output logic scl, // Bus clock, stands still high between frames
	output logic sda_oe, // Host pulls the data wire low
	input wire logic sda // Resolved data wire level
);
	logic acked; // Every byte the host sent in the last frame was acknowledged

	// ----------------------------------------
	// Idle bus
	// ----------------------------------------
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
		acked = 1'b0;
	end

	// One bit: data moves while clock is low, sampled mid clock high
	task automatic bit_io(input logic b, output logic s);
		#(HALF_NS / 4);
		sda_oe = !b;
		#(HALF_NS * 3 / 4);
		scl = 1'b1;
		#(HALF_NS / 2);
		s = sda;
		#(HALF_NS / 2);
		scl = 1'b0;
	endtask

	// Start or repeated start: data falls while clock is high
	task automatic start;
		#(HALF_NS / 4);
		sda_oe = 1'b0;
		#(HALF_NS);
		scl = 1'b1;
		#(HALF_NS);
		sda_oe = 1'b1;
		#(HALF_NS);
		scl = 1'b0;
	endtask

	// Stop: data rises while clock is high, then the bus rests
	task automatic stop;
		#(HALF_NS / 4);
		sda_oe = 1'b1;
		#(HALF_NS);
		scl = 1'b1;
		#(HALF_NS);
		sda_oe = 1'b0;
		#(HALF_NS);
	endtask

	// Byte out, most significant bit first, then the device's acknowledge
	task automatic send_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		acked = acked & !s;
	endtask

	// Byte in; the host refuses the last byte of a frame
	task automatic recv_byte(input logic last, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
		bit_io(last, s);
	endtask

	// Write frame: address, pointer, n data bytes, stop
	task automatic write_frame(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d [8], input int n);
		start();
		acked = 1'b1;
		send_byte({dev, 1'b0});
		send_byte(ptr);
		for (int i = 0; i < n; i++) send_byte(d[i]);
		stop();
	endtask

	// Read frame: set pointer, repeated start, one byte, stop
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] v);
		start();
		acked = 1'b1;
		send_byte({dev, 1'b0});
		send_byte(ptr);
		start();
		send_byte({dev, 1'b1});
		recv_byte(1'b1, v);
		stop();
	endtask
endmodule

// ===== testbench/test_param_memory_gateway_burn.sv
// Self-checking bench for the parameter memory gateway.
`timescale 1ns/1ps
module test_param_memory_gateway_burn import param_gateway_pkg::*;;
	localparam logic [6:0] DEV = 7'h2B; // Bus address, arbitrary value
	logic clk, rst, scl, sda, host_oe, sda_out, sda_oe, irq_n, params_from_nvm;
	logic [7:0] v;
	int bad_count, comparisons, cycles;

	// ----------------------------------------
	// Design, host and the pulled-up data wire
	// ----------------------------------------
	assign sda = !(host_oe || (sda_oe && !sda_out));
	param_memory_gateway_burn #(.DEV_ADDR(DEV)) param_memory_gateway_burn_inst (.clk(clk), .rst(rst),
		.scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .irq_n(irq_n),
		.params_from_nvm(params_from_nvm));
	i2c_host_model i2c_host_model_inst (.scl(scl), .sda_oe(host_oe), .sda(sda));

	// Clock and cycle ceiling
	initial clk = 1'b0;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			bad_count++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask

	function automatic logic [7:0] pat(input logic [7:0] b, input int i);
		return (b + 8'(i)) ^ 8'hC3;
	endfunction

	task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
		logic [7:0] d [8];
		d = '{default: val};
		i2c_host_model_inst.write_frame(DEV, ptr, d, 1);
		check("write ack", 8'h01, {7'h00, i2c_host_model_inst.acked});
	endtask

	task automatic rd(input logic [7:0] ptr, output logic [7:0] r);
		i2c_host_model_inst.read_reg(DEV, ptr, r);
	endtask

	// Write burst of n bytes in one frame, then terminate
	task automatic burst_write(input logic [7:0] base, input int n);
		logic [7:0] d [8];
		for (int i = 0; i < 8; i++) d[i] = pat(base, i);
		wr(OFF_CFG, 8'h10);
		wr(OFF_BASE, base);
		i2c_host_model_inst.write_frame(DEV, 8'h00, d, n);
		wr(OFF_CFG, 8'h00);
	endtask

	// Read burst of eight single reads, each compared
	task automatic burst_read(input logic [7:0] base);
		logic [7:0] r;
		wr(OFF_CFG, 8'h18);
		wr(OFF_BASE, base);
		for (int i = 0; i < 8; i++) begin
			rd(8'(i), r);
			check("shadow byte", pat(base, i), r);
		end
		wr(OFF_CFG, 8'h00);
	endtask

	// Key and trigger sequence, optionally broken by another write
	task automatic burn(input logic [7:0] k1, input logic [7:0] k2, input logic gap);
		wr(OFF_KEY_UPPER, k1);
		wr(OFF_KEY_LOWER, k2);
		if (gap) wr(OFF_CFG, 8'h00);
		wr(OFF_BASE, TRIG_FIRST);
		wr(OFF_BASE, TRIG_SECOND);
		repeat (200) @(posedge clk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		bad_count = 0;
		comparisons = 0;
		cycles = 0;
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		repeat (8) @(posedge clk);
		rd(OFF_CFG, v);
		check("config", 8'h00, v);
		rd(OFF_BASE, v);
		check("base", BASE_RESET, v);
		rd(OFF_STAT_LO, v);
		check("burn count", 8'h00, {5'h00, v[7:5]});
		check("irq_n", 8'h01, {7'h00, irq_n});
		$display("Test reset values done");
		burst_write(BASE_MAX, 8);
		check("irq_n", 8'h00, {7'h00, irq_n});
		rd(OFF_STAT_HI, v);
		check("done bit", 8'h01, {7'h00, v[STAT_DONE_BIT]});
		check("irq_n", 8'h01, {7'h00, irq_n});
		rd(OFF_STAT_HI, v);
		check("done bit", 8'h00, {7'h00, v[STAT_DONE_BIT]});
		burst_write(BASE_RESET, 8);
		rd(OFF_CFG, v);
		check("config", 8'h00, v);
		burst_write(8'h08, 7);
		check("irq_n", 8'h01, {7'h00, irq_n});
		$display("Test write bursts done");
		burst_read(BASE_MAX);
		check("irq_n", 8'h00, {7'h00, irq_n});
		burst_read(BASE_RESET);
		rd(8'h03, v);
		check("normal mode reg", 8'h00, v);
		check("irq_n", 8'h01, {7'h00, irq_n});
		$display("Test read bursts done");
		i2c_host_model_inst.write_frame(DEV ^ 7'h01, OFF_CFG, '{default: 8'h10}, 1);
		check("foreign ack", 8'h00, {7'h00, i2c_host_model_inst.acked});
		rd(OFF_KEY_UPPER, v);
		check("key readback", 8'h00, v);
		$display("Test refusals done");
		burn(8'h63, KEY_LOWER_VAL, 1'b0);
		rd(OFF_STAT_LO, v);
		check("burn count", 8'h00, {5'h00, v[7:5]});
		burn(KEY_UPPER_VAL, 8'h9C, 1'b0);
		rd(OFF_STAT_LO, v);
		check("burn count", 8'h00, {5'h00, v[7:5]});
		burn(KEY_UPPER_VAL, KEY_LOWER_VAL, 1'b1);
		rd(OFF_STAT_LO, v);
		check("burn count", 8'h00, {5'h00, v[7:5]});
		// Burns past the third check that factory set returns, and burns past the fourth that the counter stops
		for (int k = 1; k <= 5; k++) begin
			burn(KEY_UPPER_VAL, KEY_LOWER_VAL, 1'b0);
			rd(OFF_STAT_LO, v);
			check("burn count", (k > 4) ? 8'h04 : 8'(k), {5'h00, v[7:5]});
			check("nvm in use", (k < 4) ? 8'h01 : 8'h00, {7'h00, params_from_nvm});
		end
		$display("Test burns done");
		finish_test();
	end
endmodule
